// file: src/kbdhi_host_if.sv
/*
 * kbdhi_host_if: host mailbox of the embedded keyboard controller, with its
 * interrupt gating, open-drain serial lines and power-down wake logic.
 * assumes an isa-style strobe interface and a controller cpu port on clk_in.
 */
`timescale 1ns/1ps
module kbdhi_host_if (
    input wire logic clk_in,
    input wire logic nrst_in,
    // host isa side
    input wire logic [7:0] host_addr_in,
    input wire logic host_wr_in,
    input wire logic host_rd_in,
    input wire logic [7:0] host_wdata_in,
    output logic [7:0] host_rdata_out,
    output logic kbd_irq_out,
    output logic aux_irq_out,
    output logic a20_gate_out,
    // embedded cpu side
    input wire logic cpu_data_wr_in,
    input wire logic [7:0] cpu_wdata_in,
    input wire logic cpu_data_rd_in,
    output logic cpu_in_valid_out,
    output logic [7:0] cpu_input_buffer_out,
    output logic cpu_out_ready_out,
    input wire logic cpu_status_wr_in,
    output logic [7:0] cpu_status_out,
    input wire logic cpu_port2_wr_in,
    output logic [7:0] cpu_port2_out,
    input wire logic cpu_en_flags_in,
    input wire logic cpu_ibf_int_en_in,
    input wire logic cpu_halt_in,
    input wire logic cpu_stop_in,
    output logic ibf_int_out,
    output logic alu_clk_en_out,
    output logic osc_en_out,
    output logic wake_call_out,
    output logic wake_next_out,
    output logic test_input_zero_out,
    output logic test_input_one_out,
    output logic port1_bit0_out,
    output logic port1_bit1_out,
    // open-drain serial lines
    input wire logic kbd_clock_line_in,
    output logic kbd_clock_line_out,
    output logic kbd_clock_line_oe_out,
    input wire logic kbd_data_line_in,
    output logic kbd_data_line_out,
    output logic kbd_data_line_oe_out,
    input wire logic aux_clock_line_in,
    output logic aux_clock_line_out,
    output logic aux_clock_line_oe_out,
    input wire logic aux_data_line_in,
    output logic aux_data_line_out,
    output logic aux_data_line_oe_out
);
    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ----------------------------------------
    // host strobe decode
    // ----------------------------------------
    logic wr_q;
    logic rd_q;
    logic host_wr_pulse;
    logic host_rd_pulse;
    logic data_sel;
    logic ctl_sel;

    // strobes act once on their rising edge so a long isa cycle counts once
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
        end else begin
            wr_q <= host_wr_in;
            rd_q <= host_rd_in;
        end
    end

    assign data_sel = (host_addr_in == kbdhi_pkg::DATA_PORT_ADDR);
    assign ctl_sel = (host_addr_in == kbdhi_pkg::CTL_PORT_ADDR);
    assign host_wr_pulse = host_wr_in && !wr_q && (data_sel || ctl_sel);
    assign host_rd_pulse = host_rd_in && !rd_q;

    // ----------------------------------------
    // flags and persistent enable
    // ----------------------------------------
    logic flags_en;
    logic output_full_flag;
    logic input_full_flag;
    logic cmd_flag;
    logic [7:0] status_ud;
    logic [7:0] input_byte;
    logic [7:0] out_byte;
    logic [7:0] port2;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [7:0] fifo_out_data;
    logic host_data_rd;
    logic [7:0] status_byte;

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            flags_en <= 1'b0;
        end else if (cpu_en_flags_in) begin
            flags_en <= 1'b1;
        end
    end

    assign host_data_rd = host_rd_pulse && data_sel;

    // host input byte and input-full flag; a host write wins over a cpu read
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            input_full_flag <= 1'b0;
            cmd_flag <= 1'b0;
            input_byte <= 8'h00;
        end else if (host_wr_pulse) begin
            input_byte <= host_wdata_in;
            input_full_flag <= 1'b1;
            cmd_flag <= host_addr_in[kbdhi_pkg::SA2_BIT];
        end else begin
            if (cpu_data_rd_in) begin
                input_full_flag <= 1'b0;
            end
            if (cpu_status_wr_in) begin
                cmd_flag <= cpu_wdata_in[kbdhi_pkg::STAT_CD_BIT];
            end
        end
    end

    // user bits of the status byte are cpu-owned
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            status_ud <= kbdhi_pkg::STATUS_RESET;
        end else if (cpu_status_wr_in) begin
            status_ud <= cpu_wdata_in;
        end
    end

    // output-full follows the fifo head being presented to the host
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            output_full_flag <= 1'b0;
            out_byte <= 8'h00;
        end else if (!output_full_flag && fifo_out_valid) begin
            output_full_flag <= 1'b1;
            out_byte <= fifo_out_data;
        end else if (host_data_rd && flags_en) begin
            output_full_flag <= 1'b0;
        end else if (cpu_status_wr_in) begin
            output_full_flag <= cpu_wdata_in[kbdhi_pkg::STAT_OBF_BIT];
        end
    end

    assign fifo_out_ready = !output_full_flag;

    // the fifo lets firmware queue bytes ahead of a slow host
    kbdhi_fifo #(
        .WIDTH(kbdhi_pkg::FIFO_WIDTH),
        .DEPTH(kbdhi_pkg::FIFO_DEPTH)
    ) u_out_fifo (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .in_valid_in(cpu_data_wr_in),
        .in_ready_out(cpu_out_ready_out),
        .in_data_in(cpu_wdata_in),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(fifo_out_ready),
        .out_data_out(fifo_out_data)
    );

    always_comb begin
        status_byte = status_ud;
        status_byte[kbdhi_pkg::STAT_OBF_BIT] = output_full_flag;
        status_byte[kbdhi_pkg::STAT_IBF_BIT] = input_full_flag;
        status_byte[kbdhi_pkg::STAT_CD_BIT] = cmd_flag;
    end

    // ----------------------------------------
    // host read data
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            host_rdata_out <= 8'h00;
        end else if (host_rd_pulse && ctl_sel) begin
            host_rdata_out <= status_byte;
        end else if (host_data_rd) begin
            host_rdata_out <= out_byte;
        end
    end

    // ----------------------------------------
    // port 2 and interrupt outputs
    // ----------------------------------------
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            port2 <= kbdhi_pkg::PORT2_RESET;
        end else if (cpu_port2_wr_in) begin
            port2 <= cpu_wdata_in;
        end
    end

    // port2 resets high so the open-drain lines float, but kbd irq must start low
    logic port2_kbd_irq_out_seen;

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            port2_kbd_irq_out_seen <= 1'b0;
        end else if (cpu_port2_wr_in) begin
            port2_kbd_irq_out_seen <= 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            kbd_irq_out <= 1'b0;
            aux_irq_out <= 1'b0;
            a20_gate_out <= 1'b1;
        end else begin
            if (flags_en) begin
                kbd_irq_out <= port2[kbdhi_pkg::P2_KBD_IRQ_OUT_BIT] && output_full_flag;
                aux_irq_out <= port2[kbdhi_pkg::P2_AIRQ_BIT] && !input_full_flag;
            end else begin
                kbd_irq_out <= port2_kbd_irq_out_seen && port2[kbdhi_pkg::P2_KBD_IRQ_OUT_BIT];
                aux_irq_out <= port2_kbd_irq_out_seen && port2[kbdhi_pkg::P2_AIRQ_BIT];
            end
            a20_gate_out <= port2[kbdhi_pkg::P2_A20_BIT];
        end
    end

    assign cpu_status_out = status_byte;
    assign cpu_port2_out = port2;
    assign cpu_input_buffer_out = input_byte;
    assign cpu_in_valid_out = input_full_flag;
    assign ibf_int_out = input_full_flag && cpu_ibf_int_en_in;

    // ----------------------------------------
    // open-drain lines
    // ----------------------------------------
    // a port bit of one releases the line; zero pulls it low
    assign kbd_clock_line_out = 1'b0;
    assign kbd_data_line_out = 1'b0;
    assign aux_clock_line_out = 1'b0;
    assign aux_data_line_out = 1'b0;
    assign kbd_clock_line_oe_out = !port2[kbdhi_pkg::P2_KBD_CLOCK_LINE_BIT];
    assign kbd_data_line_oe_out = !port2[kbdhi_pkg::P2_KBD_DATA_LINE_BIT];
    assign aux_clock_line_oe_out = !port2[kbdhi_pkg::P2_ACLK_BIT];
    assign aux_data_line_oe_out = !port2[kbdhi_pkg::P2_ADAT_BIT];

    // three-stage sampling; a change counts once stages two and three agree
    logic [3:0] line_s1;
    logic [3:0] line_s2;
    logic [3:0] line_s3;
    logic [3:0] line_val;
    logic [3:0] line_raw;

    assign line_raw = {aux_data_line_in, aux_clock_line_in,
                       kbd_data_line_in, kbd_clock_line_in};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_line
            always_ff @(posedge clk_in or negedge rst_n) begin
                if (!rst_n) begin
                    line_s1[gi] <= 1'b1;
                    line_s2[gi] <= 1'b1;
                    line_s3[gi] <= 1'b1;
                    line_val[gi] <= 1'b1;
                end else begin
                    line_s1[gi] <= line_raw[gi];
                    line_s2[gi] <= line_s1[gi];
                    line_s3[gi] <= line_s2[gi];
                    if (line_s2[gi] == line_s3[gi]) begin
                        line_val[gi] <= line_s3[gi];
                    end
                end
            end
        end
    endgenerate

    assign test_input_zero_out = line_val[0];
    assign port1_bit0_out = line_val[1];
    assign test_input_one_out = line_val[2];
    assign port1_bit1_out = line_val[3];

    // ----------------------------------------
    // power-down control
    // ----------------------------------------
    kbdhi_pkg::kbdhi_pwr_t pwr_state;
    kbdhi_pkg::kbdhi_pwr_t next_pwr_state;
    logic wake;

    assign wake = host_wr_pulse;

    always_comb begin
        next_pwr_state = pwr_state;
        case (pwr_state)
            kbdhi_pkg::PWR_RUN: begin
                if (cpu_stop_in) begin
                    next_pwr_state = kbdhi_pkg::PWR_HARD;
                end else if (cpu_halt_in) begin
                    next_pwr_state = kbdhi_pkg::PWR_SOFT;
                end
            end
            kbdhi_pkg::PWR_SOFT, kbdhi_pkg::PWR_HARD: begin
                if (wake) begin
                    next_pwr_state = kbdhi_pkg::PWR_RUN;
                end
            end
            default: begin
                next_pwr_state = kbdhi_pkg::PWR_RUN;
            end
        endcase
    end

    // reset exit returns to run; the core restarts at address zero on rst
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pwr_state <= kbdhi_pkg::PWR_RUN;
            wake_call_out <= 1'b0;
            wake_next_out <= 1'b0;
        end else begin
            pwr_state <= next_pwr_state;
            wake_call_out <= (pwr_state != kbdhi_pkg::PWR_RUN) && wake
                && cpu_ibf_int_en_in;
            wake_next_out <= (pwr_state != kbdhi_pkg::PWR_RUN) && wake
                && !cpu_ibf_int_en_in;
        end
    end

    // the timer and interrupt logic keep running in soft power-down
    assign alu_clk_en_out = (pwr_state == kbdhi_pkg::PWR_RUN);
    assign osc_en_out = (pwr_state != kbdhi_pkg::PWR_HARD);
endmodule

// file: src/kbdhi_pkg.sv
/*
 * kbdhi_pkg: constants shared by the keyboard host mailbox and its fifo.
 * assumes nothing of its surroundings; used by package::name only.
 */
package kbdhi_pkg;
    // ----------------------------------------
    // host i/o addresses
    // ----------------------------------------
    localparam logic [7:0] DATA_PORT_ADDR = 8'h60;
    localparam logic [7:0] CTL_PORT_ADDR = 8'h64;
    localparam int SA2_BIT = 2;
    // ----------------------------------------
    // status byte layout and reset
    // ----------------------------------------
    localparam int STAT_OBF_BIT = 0;
    localparam int STAT_IBF_BIT = 1;
    localparam int STAT_CD_BIT = 3;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] PORT2_RESET = 8'hff;
    // ----------------------------------------
    // port-2 bit positions
    // ----------------------------------------
    localparam int P2_A20_BIT = 1;
    localparam int P2_ADAT_BIT = 2;
    localparam int P2_ACLK_BIT = 3;
    localparam int P2_KBD_IRQ_OUT_BIT = 4;
    localparam int P2_AIRQ_BIT = 5;
    localparam int P2_KBD_CLOCK_LINE_BIT = 6;
    localparam int P2_KBD_DATA_LINE_BIT = 7;
    // ----------------------------------------
    // fifo shape
    // ----------------------------------------
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 16;
    // ----------------------------------------
    // power state
    // ----------------------------------------
    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_SOFT,
        PWR_HARD
    } kbdhi_pwr_t;
endpackage

// file: src/kbdhi_fifo.sv
/*
 * kbdhi_fifo: flip-flop fifo with valid/ready on both sides.
 * assumes one clock and a synchronous-released active-low reset.
 */
`timescale 1ns/1ps
module kbdhi_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready_out = (count != (AW+1)'(DEPTH));
    assign out_valid_out = (count != '0);
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = mem[rd_ptr];

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// file: verification/kbdhi_host_if_props.sv
/*
 * kbdhi_host_if_props: concurrent checks on the keyboard host mailbox ports.
 * assumes it is bound into kbdhi_host_if and sees only that module's ports.
 */
`timescale 1ns/1ps
module kbdhi_host_if_props (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [7:0] host_addr_in,
    input wire logic host_wr_in,
    input wire logic host_rd_in,
    input wire logic [7:0] host_wdata_in,
    input wire logic [7:0] host_rdata_out,
    input wire logic kbd_irq_out,
    input wire logic aux_irq_out,
    input wire logic a20_gate_out,
    input wire logic cpu_data_wr_in,
    input wire logic cpu_data_rd_in,
    input wire logic cpu_out_ready_out,
    input wire logic [7:0] cpu_input_buffer_out,
    input wire logic [7:0] cpu_status_out,
    input wire logic cpu_port2_wr_in,
    input wire logic [7:0] cpu_port2_out,
    input wire logic cpu_en_flags_in,
    input wire logic cpu_ibf_int_en_in,
    input wire logic cpu_halt_in,
    input wire logic cpu_stop_in,
    input wire logic alu_clk_en_out,
    input wire logic osc_en_out,
    input wire logic wake_call_out,
    input wire logic wake_next_out,
    input wire logic kbd_clock_line_oe_out,
    input wire logic kbd_data_line_oe_out,
    input wire logic aux_clock_line_oe_out,
    input wire logic aux_data_line_oe_out
);
    // tracks flag mode and first port2 write, which the irq outputs depend on
    logic en_q;
    logic p2w_q;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            en_q <= 1'b0;
            p2w_q <= 1'b0;
        end else begin
            en_q <= en_q | cpu_en_flags_in;
            p2w_q <= p2w_q | cpu_port2_wr_in;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    property p_host_wr;
        $rose(host_wr_in) && (host_addr_in == 8'h60 || host_addr_in == 8'h64) |=>
            cpu_status_out[1] && cpu_status_out[3] == $past(host_addr_in[2])
            && cpu_input_buffer_out == $past(host_wdata_in);
    endproperty
    a_host_wr: assert property (p_host_wr) else $error("host write not latched");
    property p_stat_rd;
        $rose(host_rd_in) && host_addr_in == 8'h64 |=> host_rdata_out == $past(cpu_status_out);
    endproperty
    a_stat_rd: assert property (p_stat_rd) else $error("status read wrong");
    property p_ibf_clr;
        cpu_data_rd_in && !$rose(host_wr_in) |=> !cpu_status_out[1];
    endproperty
    a_ibf_clr: assert property (p_ibf_clr) else $error("input full not cleared");
    property p_obf_set;
        cpu_data_wr_in && cpu_out_ready_out && !cpu_status_out[0] |-> ##[1:3] cpu_status_out[0];
    endproperty
    a_obf_set: assert property (p_obf_set) else $error("output full not set");
    property p_irq_port;
        p2w_q && !en_q |=> kbd_irq_out == $past(cpu_port2_out[4])
            && aux_irq_out == $past(cpu_port2_out[5]);
    endproperty
    a_irq_port: assert property (p_irq_port) else $error("port irq wrong");
    property p_irq_flag;
        p2w_q && en_q |=> kbd_irq_out == $past(cpu_port2_out[4] & cpu_status_out[0])
            && aux_irq_out == $past(cpu_port2_out[5] & ~cpu_status_out[1]);
    endproperty
    a_irq_flag: assert property (p_irq_flag) else $error("flag irq wrong");
    property p_irq_rst;
        !p2w_q && !en_q |-> !kbd_irq_out && !aux_irq_out;
    endproperty
    a_irq_rst: assert property (p_irq_rst) else $error("irq not low");
    property p_a20;
        a20_gate_out == $past(cpu_port2_out[1]);
    endproperty
    a_a20: assert property (p_a20) else $error("a20 gate wrong");
    property p_lines;
        {kbd_clock_line_oe_out, kbd_data_line_oe_out, aux_clock_line_oe_out, aux_data_line_oe_out}
            == ~{cpu_port2_out[6], cpu_port2_out[7], cpu_port2_out[3], cpu_port2_out[2]};
    endproperty
    a_lines: assert property (p_lines) else $error("line enables wrong");
    property p_halt;
        cpu_halt_in && !cpu_stop_in && alu_clk_en_out && osc_en_out && !$rose(host_wr_in)
            |=> !alu_clk_en_out && osc_en_out;
    endproperty
    a_halt: assert property (p_halt) else $error("halt not entered");
    property p_stop;
        cpu_stop_in && alu_clk_en_out && osc_en_out && !$rose(host_wr_in) |=> !osc_en_out;
    endproperty
    a_stop: assert property (p_stop) else $error("stop not entered");
    property p_wake;
        !alu_clk_en_out && $rose(host_wr_in) && host_addr_in inside {8'h60, 8'h64}
            |-> ##[1:2] (wake_call_out | wake_next_out) && wake_call_out == cpu_ibf_int_en_in;
    endproperty
    a_wake: assert property (p_wake) else $error("wake kind wrong");
    c_kbd_irq_out: cover property (en_q && kbd_irq_out);
    c_full: cover property (!cpu_out_ready_out);
    c_call: cover property (wake_call_out);
endmodule

// file: verification/kbdhi_line_model.sv
/*
 * kbdhi_line_model: keyboard and mouse side of the four open-drain lines.
 * assumes external pull-ups; bit order kbd clock, kbd data, aux clock, aux data.
 */
`timescale 1ns/1ps
module kbdhi_line_model (
    input wire logic [3:0] oe_in,
    input wire logic [3:0] drv_in,
    input wire logic [3:0] pull_in,
    output logic [3:0] line_out
);
    // wired-and: either party pulling low wins, else the pull-up holds it high
    assign line_out = ~((oe_in & ~drv_in) | pull_in);
endmodule

// file: verification/kbd_controller_host_interface_tb.sv
/*
 * kbd_controller_host_interface_tb: directed self-checking bench of the mailbox.
 * assumes kbdhi_host_if, kbdhi_line_model and the props checker are compiled.
 */
`timescale 1ns/1ps
module kbd_controller_host_interface_tb;
    logic clk_in, nrst_in, host_wr_in, host_rd_in, kbd_irq_out, aux_irq_out, a20_gate_out;
    logic cpu_data_wr_in, cpu_data_rd_in, cpu_in_valid_out, cpu_out_ready_out, cpu_status_wr_in;
    logic cpu_port2_wr_in, cpu_en_flags_in, cpu_ibf_int_en_in, cpu_halt_in, cpu_stop_in;
    logic ibf_int_out, alu_clk_en_out, osc_en_out, wake_call_out, wake_next_out;
    logic test_input_zero_out, test_input_one_out, port1_bit0_out, port1_bit1_out;
    logic kbd_clock_line_in, kbd_clock_line_out, kbd_clock_line_oe_out;
    logic kbd_data_line_in, kbd_data_line_out, kbd_data_line_oe_out;
    logic aux_clock_line_in, aux_clock_line_out, aux_clock_line_oe_out;
    logic aux_data_line_in, aux_data_line_out, aux_data_line_oe_out;
    logic [7:0] host_addr_in, host_wdata_in, host_rdata_out, cpu_wdata_in, cpu_input_buffer_out;
    logic [7:0] cpu_status_out, cpu_port2_out;
    logic [3:0] pull;
    int num_errors, num_checks, n_call, n_next, n;
    kbdhi_host_if u_kbdhi_host_if (.*);
    kbdhi_line_model u_kbdhi_line_model (
        .oe_in({kbd_clock_line_oe_out, kbd_data_line_oe_out, aux_clock_line_oe_out,
            aux_data_line_oe_out}),
        .drv_in({kbd_clock_line_out, kbd_data_line_out, aux_clock_line_out,
            aux_data_line_out}),
        .pull_in(pull),
        .line_out({kbd_clock_line_in, kbd_data_line_in, aux_clock_line_in, aux_data_line_in})
    );
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        n_call += (wake_call_out === 1'b1);
        n_next += (wake_next_out === 1'b1);
    end
    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task hw(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        host_addr_in <= a;
        host_wdata_in <= d;
        host_wr_in <= 1'b1;
        @(posedge clk_in);
        host_wr_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        #1;
    endtask
    task hr(input logic [7:0] a, input logic [7:0] e, input string nm);
        @(posedge clk_in);
        host_addr_in <= a;
        host_rd_in <= 1'b1;
        @(posedge clk_in);
        host_rd_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        #1;
        chk(nm, e, host_rdata_out);
    endtask
    task cp(input int k, input logic [7:0] d);
        @(posedge clk_in);
        cpu_wdata_in <= d;
        case (k)
            0: cpu_data_wr_in <= 1'b1;
            1: cpu_data_rd_in <= 1'b1;
            2: cpu_status_wr_in <= 1'b1;
            3: cpu_port2_wr_in <= 1'b1;
            4: cpu_en_flags_in <= 1'b1;
            5: cpu_halt_in <= 1'b1;
            default: cpu_stop_in <= 1'b1;
        endcase
        @(posedge clk_in);
        {cpu_data_wr_in, cpu_data_rd_in, cpu_status_wr_in, cpu_port2_wr_in, cpu_en_flags_in,
            cpu_halt_in, cpu_stop_in} <= '0;
        repeat (4) @(posedge clk_in);
        #1;
    endtask
    task stop_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        {nrst_in, host_wr_in, host_rd_in, cpu_data_wr_in, cpu_data_rd_in, cpu_status_wr_in,
            cpu_port2_wr_in, cpu_en_flags_in, cpu_ibf_int_en_in, cpu_halt_in, cpu_stop_in} = '0;
        {host_addr_in, host_wdata_in, cpu_wdata_in, pull} = '0;
        repeat (6) @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        hr(8'h64, 8'h00, "status_reset");
        chk("irq_reset", 8'h00, 8'({kbd_irq_out, aux_irq_out}));
        hw(8'h60, 8'ha5);
        chk("in_buf", 8'ha5, cpu_input_buffer_out);
        hr(8'h64, 8'h02, "status_data");
        hw(8'h64, 8'h5a);
        hr(8'h64, 8'h0a, "status_cmd");
        // write to an unmapped address must leave the buffer alone
        hw(8'h61, 8'h11);
        chk("in_buf_unmapped", 8'h5a, cpu_input_buffer_out);
        cp(1, 8'h00);
        hr(8'h64, 8'h08, "status_cpu_read");
        cp(2, 8'hf2);
        hr(8'h64, 8'hf0, "status_cpu_write");
        cp(2, 8'h00);
        cp(3, 8'h30);
        chk("irq_port_on", 8'h03, 8'({kbd_irq_out, aux_irq_out}));
        chk("a20_low", 8'h00, 8'(a20_gate_out));
        chk("lines_low", 8'h00, 8'({test_input_zero_out, port1_bit0_out, test_input_one_out,
            port1_bit1_out}));
        @(posedge clk_in);
        pull <= 4'b0101;
        cp(3, 8'hce);
        chk("irq_port_off", 8'h00, 8'({kbd_irq_out, aux_irq_out}));
        chk("a20_high", 8'h01, 8'(a20_gate_out));
        chk("lines_dev", 8'h0a, 8'({test_input_zero_out, port1_bit0_out, test_input_one_out,
            port1_bit1_out}));
        @(posedge clk_in);
        pull <= 4'b0000;
        cp(4, 8'h00);
        cp(3, 8'h30);
        chk("irq_flags", 8'h01, 8'({kbd_irq_out, aux_irq_out}));
        @(posedge clk_in);
        cpu_ibf_int_en_in <= 1'b1;
        hw(8'h60, 8'h77);
        chk("aux_ibf", 8'h03,
            8'({kbd_irq_out, aux_irq_out, ibf_int_out, cpu_in_valid_out}));
        cp(1, 8'h00);
        cp(0, 8'h3c);
        chk("kbd_irq_out_obf", 8'h03, 8'({kbd_irq_out, aux_irq_out}));
        hr(8'h60, 8'h3c, "out_byte");
        hr(8'h64, 8'h00, "status_after_read");
        chk("kbd_irq_out_clear", 8'h01, 8'({kbd_irq_out, aux_irq_out}));
        n = 0;
        while (cpu_out_ready_out === 1'b1 && n < 40) begin
            cp(0, n[7:0]);
            n++;
        end
        // the first byte moves straight into the output register, so one extra fits
        chk("fifo_full", 8'(kbdhi_pkg::FIFO_DEPTH + 1), 8'(n));
        for (int i = 0; i < n; i++)
            hr(8'h60, i[7:0], "fifo_byte");
        cp(5, 8'h00);
        chk("halt", 8'h01, 8'({alu_clk_en_out, osc_en_out}));
        hw(8'h64, 8'h00);
        chk("wake_call", 8'h07, 8'({n_call[3:0], alu_clk_en_out, osc_en_out}));
        @(posedge clk_in);
        cpu_ibf_int_en_in <= 1'b0;
        cp(6, 8'h00);
        chk("stop", 8'h00, 8'(osc_en_out));
        hw(8'h60, 8'h01);
        chk("wake_next", 8'h07, 8'({n_next[3:0], alu_clk_en_out, osc_en_out}));
        // second reset must drop flag mode and clear status
        @(posedge clk_in);
        nrst_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        nrst_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        hr(8'h64, 8'h00, "status_rereset");
        cp(3, 8'h30);
        chk("irq_port_again", 8'h03, 8'({kbd_irq_out, aux_irq_out}));
        stop_test;
    end
    initial begin
        #50000;
        num_errors++;
        stop_test;
    end
endmodule
bind kbdhi_host_if kbdhi_host_if_props u_kbdhi_host_if_props (.*);
